// ### rtl/acfm_top.sv
// Audio clock failure monitor: registers, autoswitch, mute, tx restart
`timescale 1ns/1ps
module acfm_top
  import acfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regReadData,
  input wire logic txHighFreqClockIn,
  output logic txHighFreqClockOut,
  output logic txHighFreqClockOe_n,
  input wire logic rxHighFreqClock,
  input wire logic txDataValid,
  input wire logic txDataBit,
  output logic txSerialOut,
  output logic txSectionReset,
  output logic txFailIrq,
  output logic rxFailIrq,
  output logic muteOut
);
  logic [PS_W-1:0] txPrescale, next_txPrescale;
  logic [PS_W-1:0] rxPrescale, next_rxPrescale;
  logic [BOUND_W-1:0] txLower, next_txLower, txUpper, next_txUpper;
  logic [BOUND_W-1:0] rxLower, next_rxLower, rxUpper, next_rxUpper;
  logic txAutoSwitch, next_txAutoSwitch;
  logic txFailFlag, next_txFailFlag, rxFailFlag, next_rxFailFlag;
  logic txIntEn, next_txIntEn, rxIntEn, next_rxIntEn;
  logic muteTxEn, next_muteTxEn, muteRxEn, next_muteRxEn;
  logic muteLevel, next_muteLevel;
  logic [DIV_W-1:0] txDivRatio, next_txDivRatio;
  logic txSourceSel, next_txSourceSel;
  logic txDivRun, next_txDivRun, rxDivRun, next_rxDivRun;
  logic spdifMode, next_spdifMode;
  logic [DATA_W-1:0] next_regReadData;
  logic next_txFailIrq, next_rxFailIrq, next_muteOut;
  logic next_txHighFreqClockOe_n;
  logic [BOUND_W-1:0] txMeasured, rxMeasured;
  logic txFailEvent, rxFailEvent;
  logic divClock, divRise;
  logic txClkSel, txClkPrev, rxClkPrev, txRise, rxRise;
  logic switchStart;
  acfm_switch_state_t swState, next_swState;
  logic next_txSectionReset;
  logic [1:0] patIdx, next_patIdx;
  logic next_txSerialOut;
  logic awaitFirstBit, next_awaitFirstBit;
  always_comb begin
    txClkSel = txSourceSel ? divClock : txHighFreqClockIn;
    txRise = txClkSel && !txClkPrev;
    rxRise = rxHighFreqClock && !rxClkPrev;
    switchStart = txFailEvent && spdifMode && txAutoSwitch &&
      !txSourceSel;
  end
  // Divider runs only when software releases it
  acfm_clock_divider #(.RATIO_W(DIV_W)) u_txDivider (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(txDivRun),
    .restart(switchStart),
    .ratio(txDivRatio),
    .clockOut(divClock),
    .risePulse(divRise)
  );
  acfm_clock_check #(.WINDOW(WINDOW_PERIODS)) u_txCheck (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(txDivRun),
    .clockRise(txRise),
    .prescale(txPrescale),
    .lowerBound(txLower),
    .upperBound(txUpper),
    .measuredCount(txMeasured),
    .failEvent(txFailEvent)
  );
  acfm_clock_check #(.WINDOW(WINDOW_PERIODS)) u_rxCheck (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(rxDivRun),
    .clockRise(rxRise),
    .prescale(rxPrescale),
    .lowerBound(rxLower),
    .upperBound(rxUpper),
    .measuredCount(rxMeasured),
    .failEvent(rxFailEvent)
  );
  // Register file and sticky flags
  always_comb begin
    next_txPrescale = txPrescale;
    next_rxPrescale = rxPrescale;
    next_txLower = txLower;
    next_txUpper = txUpper;
    next_rxLower = rxLower;
    next_rxUpper = rxUpper;
    next_txAutoSwitch = txAutoSwitch;
    next_txFailFlag = txFailFlag;
    next_rxFailFlag = rxFailFlag;
    next_txIntEn = txIntEn;
    next_rxIntEn = rxIntEn;
    next_muteTxEn = muteTxEn;
    next_muteRxEn = muteRxEn;
    next_muteLevel = muteLevel;
    next_txDivRatio = txDivRatio;
    next_txSourceSel = txSourceSel;
    next_txDivRun = txDivRun;
    next_rxDivRun = rxDivRun;
    next_spdifMode = spdifMode;
    if (regWrite) begin
      unique case (regAddr)
        OFF_TX_CHECK: begin
          next_txPrescale = regWriteData[CHK_PS_LSB +: PS_W];
          next_txAutoSwitch = regWriteData[CHK_SW_BIT];
          next_txLower = regWriteData[CHK_MIN_LSB +: BOUND_W];
          next_txUpper = regWriteData[CHK_MAX_LSB +: BOUND_W];
        end
        OFF_RX_CHECK: begin
          // Receive side has no autoswitch bit
          next_rxPrescale = regWriteData[CHK_PS_LSB +: PS_W];
          next_rxLower = regWriteData[CHK_MIN_LSB +: BOUND_W];
          next_rxUpper = regWriteData[CHK_MAX_LSB +: BOUND_W];
        end
        OFF_TX_STATUS: begin
          if (regWriteData[STAT_FAIL_BIT]) next_txFailFlag = 1'b0;
        end
        OFF_RX_STATUS: begin
          if (regWriteData[STAT_FAIL_BIT]) next_rxFailFlag = 1'b0;
        end
        OFF_TX_INT: next_txIntEn = regWriteData[INT_FAIL_BIT];
        OFF_RX_INT: next_rxIntEn = regWriteData[INT_FAIL_BIT];
        OFF_MUTE: begin
          next_muteTxEn = regWriteData[MUTE_TX_BIT];
          next_muteRxEn = regWriteData[MUTE_RX_BIT];
          next_muteLevel = regWriteData[MUTE_LEVEL_BIT];
        end
        OFF_TX_HCLK: begin
          next_txDivRatio = regWriteData[HCLK_DIV_LSB +: DIV_W];
          next_txSourceSel = regWriteData[HCLK_SEL_BIT];
          next_txDivRun = regWriteData[HCLK_RUN_BIT];
        end
        OFF_MODE: begin
          next_spdifMode = regWriteData[MODE_SPDIF_BIT];
          next_rxDivRun = regWriteData[MODE_RX_RUN_BIT];
        end
        default: ;
      endcase
    end
    // Hardware set beats a same-cycle software clear
    if (txFailEvent) next_txFailFlag = 1'b1;
    if (rxFailEvent) next_rxFailFlag = 1'b1;
    if (switchStart) next_txSourceSel = 1'b1;
    next_regReadData = '0;
    if (regRead) begin
      unique case (regAddr)
        OFF_TX_CHECK: next_regReadData = {txMeasured, txUpper, txLower,
          txAutoSwitch, 3'h0, txPrescale};
        OFF_RX_CHECK: next_regReadData = {rxMeasured, rxUpper, rxLower,
          4'h0, rxPrescale};
        OFF_TX_STATUS: next_regReadData = {31'h0, txFailFlag};
        OFF_RX_STATUS: next_regReadData = {31'h0, rxFailFlag};
        OFF_TX_INT: next_regReadData = {31'h0, txIntEn};
        OFF_RX_INT: next_regReadData = {31'h0, rxIntEn};
        OFF_MUTE: next_regReadData = {29'h0, muteLevel, muteRxEn, muteTxEn};
        OFF_TX_HCLK: next_regReadData = {22'h0, txDivRun, txSourceSel,
          txDivRatio};
        OFF_MODE: next_regReadData = {30'h0, rxDivRun, spdifMode};
        default: next_regReadData = '0;
      endcase
    end
    next_txFailIrq = next_txFailFlag && next_txIntEn;
    next_rxFailIrq = next_rxFailFlag && next_rxIntEn;
    next_muteOut = ((next_txFailFlag && next_muteTxEn) ||
      (next_rxFailFlag && next_muteRxEn)) ? next_muteLevel
      : !next_muteLevel;
    // Pin never driven while the failure flag stands
    next_txHighFreqClockOe_n = !(next_txSourceSel &&
      !next_txFailFlag);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      txPrescale <= RST_PRESCALE;
      rxPrescale <= RST_PRESCALE;
      txLower <= RST_LOWER;
      txUpper <= RST_UPPER;
      rxLower <= RST_LOWER;
      rxUpper <= RST_UPPER;
      txAutoSwitch <= 1'b0;
      txFailFlag <= 1'b0;
      rxFailFlag <= 1'b0;
      txIntEn <= 1'b0;
      rxIntEn <= 1'b0;
      muteTxEn <= 1'b0;
      muteRxEn <= 1'b0;
      muteLevel <= 1'b0;
      txDivRatio <= RST_DIV_RATIO;
      txSourceSel <= 1'b0;
      txDivRun <= 1'b0;
      rxDivRun <= 1'b0;
      spdifMode <= 1'b0;
      regReadData <= '0;
      txFailIrq <= 1'b0;
      rxFailIrq <= 1'b0;
      muteOut <= 1'b1;
      txHighFreqClockOe_n <= 1'b1;
      txClkPrev <= 1'b0;
      rxClkPrev <= 1'b0;
    end else begin
      txPrescale <= next_txPrescale;
      rxPrescale <= next_rxPrescale;
      txLower <= next_txLower;
      txUpper <= next_txUpper;
      rxLower <= next_rxLower;
      rxUpper <= next_rxUpper;
      txAutoSwitch <= next_txAutoSwitch;
      txFailFlag <= next_txFailFlag;
      rxFailFlag <= next_rxFailFlag;
      txIntEn <= next_txIntEn;
      rxIntEn <= next_rxIntEn;
      muteTxEn <= next_muteTxEn;
      muteRxEn <= next_muteRxEn;
      muteLevel <= next_muteLevel;
      txDivRatio <= next_txDivRatio;
      txSourceSel <= next_txSourceSel;
      txDivRun <= next_txDivRun;
      rxDivRun <= next_rxDivRun;
      spdifMode <= next_spdifMode;
      regReadData <= next_regReadData;
      txFailIrq <= next_txFailIrq;
      rxFailIrq <= next_rxFailIrq;
      muteOut <= next_muteOut;
      txHighFreqClockOe_n <= next_txHighFreqClockOe_n;
      txClkPrev <= txClkSel;
      rxClkPrev <= rxHighFreqClock;
    end
  end
  assign txHighFreqClockOut = divClock;
  // Autoswitch restart and transmit bit stage
  always_comb begin
    next_swState = swState;
    next_patIdx = patIdx;
    next_txSerialOut = txSerialOut;
    unique case (swState)
      ACFM_SW_IDLE: if (switchStart) next_swState = ACFM_SW_HOLD;
      ACFM_SW_HOLD: if (divRise) next_swState = ACFM_SW_IDLE;
    endcase
    next_txSectionReset = next_swState == ACFM_SW_HOLD;
    // Armed during the hold, spent on the first clock rise after it
    next_awaitFirstBit = txRise ? 1'b0 : awaitFirstBit | txSectionReset;
    if (next_txSectionReset) begin
      next_patIdx = '0;
      next_txSerialOut = 1'b0;
    end else if (txRise) begin
      if (txDataValid) begin
        next_txSerialOut = txDataBit;
      end else begin
        // Underrun repeats biphase-mark zeros so a receiver keeps lock
        next_txSerialOut = UNDERRUN_PATTERN[2'd3 - patIdx];
        next_patIdx = patIdx + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      swState <= ACFM_SW_IDLE;
      txSectionReset <= 1'b0;
      patIdx <= '0;
      txSerialOut <= 1'b0;
      awaitFirstBit <= 1'b0;
    end else begin
      swState <= next_swState;
      txSectionReset <= next_txSectionReset;
      patIdx <= next_patIdx;
      txSerialOut <= next_txSerialOut;
      awaitFirstBit <= next_awaitFirstBit;
    end
  end

  a_fail_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    txFailFlag && !(regWrite && regAddr == OFF_TX_STATUS &&
    regWriteData[STAT_FAIL_BIT]) |=> txFailFlag)
    else $error("tx failure flag dropped without a clear");
  a_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
    rxFailEvent |=> rxFailFlag)
    else $error("rx failure event lost");
  a_irq_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    txFailIrq |-> txFailFlag && txIntEn)
    else $error("tx interrupt without enabled flag");
  a_switch_select: assert property (@(posedge core_clk) disable iff (!reset_n)
    switchStart |=> txSourceSel && txSectionReset &&
    txDivRatio == $past(txDivRatio))
    else $error("autoswitch did not select internal divider");
  a_hold_release: assert property (@(posedge core_clk) disable iff (!reset_n)
    txSectionReset && divRise |=> !txSectionReset)
    else $error("tx section held past one period");
  a_no_drive_fail: assert property (@(posedge core_clk) disable iff (!reset_n)
    txFailFlag |-> txHighFreqClockOe_n)
    else $error("high clock pin driven while failed");
  a_mute_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    txFailFlag && muteTxEn |-> muteOut == muteLevel)
    else $error("mute output not at programmed level");
  a_underrun_first: assert property (@(posedge core_clk) disable iff (!reset_n)
    awaitFirstBit && txRise && !txDataValid |=> txSerialOut)
    else $error("underrun did not start with pattern one");
  c_tx_fail: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(txFailFlag));
  c_autoswitch: cover property (@(posedge core_clk) disable iff (!reset_n)
    switchStart ##[1:1000] $fell(txSectionReset));
  c_rx_mute: cover property (@(posedge core_clk) disable iff (!reset_n)
    rxFailFlag && muteRxEn && muteOut == muteLevel);
endmodule : acfm_top

// ### rtl/acfm_pkg.sv
// Constants, register map and types of the audio clock failure monitor
package acfm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_TX_CHECK = 8'h00;
  localparam logic [7:0] OFF_RX_CHECK = 8'h04;
  localparam logic [7:0] OFF_TX_STATUS = 8'h08;
  localparam logic [7:0] OFF_RX_STATUS = 8'h0c;
  localparam logic [7:0] OFF_TX_INT = 8'h10;
  localparam logic [7:0] OFF_RX_INT = 8'h14;
  localparam logic [7:0] OFF_MUTE = 8'h18;
  localparam logic [7:0] OFF_TX_HCLK = 8'h1c;
  localparam logic [7:0] OFF_MODE = 8'h20;

  // Clock check control fields
  localparam int PS_W = 4;
  localparam int BOUND_W = 8;
  localparam int CHK_PS_LSB = 0;
  localparam int CHK_SW_BIT = 7;
  localparam int CHK_MIN_LSB = 8;
  localparam int CHK_MAX_LSB = 16;
  localparam int CHK_CNT_LSB = 24;

  // Single-bit fields and the 8-bit divide ratio field
  localparam int STAT_FAIL_BIT = 0;
  localparam int INT_FAIL_BIT = 0;
  localparam int MUTE_TX_BIT = 0;
  localparam int MUTE_RX_BIT = 1;
  localparam int MUTE_LEVEL_BIT = 2;
  localparam int DIV_W = 8;
  localparam int HCLK_DIV_LSB = 0;
  localparam int HCLK_SEL_BIT = 8;
  localparam int HCLK_RUN_BIT = 9;
  localparam int MODE_SPDIF_BIT = 0;
  localparam int MODE_RX_RUN_BIT = 1;

  // Values after reset
  localparam logic [BOUND_W-1:0] RST_LOWER = 8'h00;
  localparam logic [BOUND_W-1:0] RST_UPPER = 8'hff;
  localparam logic [PS_W-1:0] RST_PRESCALE = 4'h0;
  localparam logic [DIV_W-1:0] RST_DIV_RATIO = 8'h00;

  // Measurement window, counters and underrun pattern
  localparam int WINDOW_PERIODS = 32;
  localparam int WIN_W = $clog2(WINDOW_PERIODS);
  localparam int RUN_CNT_W = BOUND_W + 1;
  localparam logic [3:0] UNDERRUN_PATTERN = 4'hc;

  typedef enum logic [0:0] {ACFM_SW_IDLE, ACFM_SW_HOLD} acfm_switch_state_t;
endpackage : acfm_pkg

// ### rtl/acfm_clock_divider.sv
// Internal high-frequency clock divider with restart to a full period
`timescale 1ns/1ps
module acfm_clock_divider
  import acfm_pkg::*;
#(
  parameter int RATIO_W = DIV_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [RATIO_W-1:0] ratio,
  output logic clockOut,
  output logic risePulse
);
  logic [RATIO_W-1:0] count;
  logic [RATIO_W-1:0] next_count;
  logic next_clockOut;
  logic next_risePulse;

  always_comb begin
    next_count = count;
    next_clockOut = clockOut;
    next_risePulse = 1'b0;
    if (!run) begin
      next_count = '0;
      next_clockOut = 1'b0;
    end else if (restart) begin
      // Period starts with its high half, so it ends on the next rise
      next_count = '0;
      next_clockOut = 1'b1;
    end else if (count == ratio) begin
      next_count = '0;
      next_clockOut = !clockOut;
      next_risePulse = !clockOut;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      clockOut <= 1'b0;
      risePulse <= 1'b0;
    end else begin
      count <= next_count;
      clockOut <= next_clockOut;
      risePulse <= next_risePulse;
    end
  end

  a_restart_full: assert property (@(posedge core_clk) disable iff (!reset_n)
    run && restart |=> clockOut && count == '0)
    else $error("divider did not restart to a full period");
endmodule : acfm_clock_divider

// ### rtl/acfm_clock_check.sv
// One clock check channel: window count, latch and bound compare
`timescale 1ns/1ps
module acfm_clock_check
  import acfm_pkg::*;
#(
  parameter int WINDOW = WINDOW_PERIODS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic clockRise,
  input wire logic [PS_W-1:0] prescale,
  input wire logic [BOUND_W-1:0] lowerBound,
  input wire logic [BOUND_W-1:0] upperBound,
  output logic [BOUND_W-1:0] measuredCount,
  output logic failEvent
);
  localparam int WW = $clog2(WINDOW);
  localparam logic [WW-1:0] WIN_LAST = WW'(WINDOW - 1);
  localparam logic [RUN_CNT_W-1:0] RUN_MAX = '1;

  logic [PS_W-1:0] psCount, next_psCount;
  logic [RUN_CNT_W-1:0] runCount, next_runCount;
  logic [WW-1:0] winCount, next_winCount;
  logic [BOUND_W-1:0] next_measuredCount;
  logic next_failEvent;
  logic tick;
  logic windowEnd;
  logic [BOUND_W-1:0] satCount;

  always_comb begin
    tick = psCount == prescale;
    windowEnd = run && clockRise && winCount == WIN_LAST;
    satCount = runCount[RUN_CNT_W-1] ? '1 : runCount[BOUND_W-1:0];
    next_psCount = tick ? '0 : psCount + 1'b1;
    next_runCount = runCount;
    if (tick && runCount != RUN_MAX) begin
      next_runCount = runCount + 1'b1;
    end
    next_winCount = clockRise ? winCount + 1'b1 : winCount;
    next_measuredCount = measuredCount;
    if (windowEnd) begin
      next_measuredCount = satCount;
      next_runCount = '0;
      next_psCount = '0;
    end
    if (!run) begin
      next_psCount = '0;
      next_runCount = '0;
      next_winCount = '0;
    end
    // Unsigned compares; max side catches a stopped clock
    next_failEvent = run && ((windowEnd && satCount < lowerBound) ||
      runCount > {1'b0, upperBound});
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      psCount <= '0;
      runCount <= '0;
      winCount <= '0;
      measuredCount <= '0;
      failEvent <= 1'b0;
    end else begin
      psCount <= next_psCount;
      runCount <= next_runCount;
      winCount <= next_winCount;
      measuredCount <= next_measuredCount;
      failEvent <= next_failEvent;
    end
  end

  a_window_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    windowEnd |=> measuredCount == $past(satCount) && runCount == '0)
    else $error("window count not latched");
  a_max_detect: assert property (@(posedge core_clk) disable iff (!reset_n)
    run && runCount > {1'b0, upperBound} |=> failEvent)
    else $error("running count above bound not flagged");
  a_min_detect: assert property (@(posedge core_clk) disable iff (!reset_n)
    windowEnd && satCount < lowerBound |=> failEvent)
    else $error("short window not flagged");
endmodule : acfm_clock_check

// ### sim/acfm_clock_source.sv
// External high clock source model for the tx and rx checks
`timescale 1ns/1ps
module acfm_clock_source #(
  parameter int HALF = 2
) (
  input wire logic core_clk,
  input wire logic stopTx,
  input wire logic stopRx,
  output logic txClk,
  output logic rxClk
);
  int cntTx = 0;
  int cntRx = 0;
  initial begin
    txClk = 1'b0;
    rxClk = 1'b0;
  end
  // A stopped source stands still low, as a dead oscillator would
  always @(posedge core_clk) begin
    cntTx <= (cntTx == HALF - 1) ? 0 : cntTx + 1;
    cntRx <= (cntRx == HALF - 1) ? 0 : cntRx + 1;
    if (cntTx == HALF - 1) txClk <= stopTx ? 1'b0 : ~txClk;
    if (cntRx == HALF - 1) rxClk <= stopRx ? 1'b0 : ~rxClk;
  end
endmodule : acfm_clock_source

// ### sim/acfm_top_bench.sv
// Register level bench of the audio clock failure monitor
`timescale 1ns/1ps
module acfm_top_bench
  import acfm_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWriteData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regReadData;
  logic txHighFreqClockIn;
  logic txHighFreqClockOut;
  logic txHighFreqClockOe_n;
  logic rxHighFreqClock;
  logic txDataValid = 1'b0;
  logic txDataBit = 1'b0;
  logic txSerialOut;
  logic txSectionReset;
  logic txFailIrq;
  logic rxFailIrq;
  logic muteOut;
  logic extTx;
  logic stopTx = 1'b0;
  logic stopRx = 1'b0;
  logic [31:0] d;
  logic s[8];
  int n;
  int mismatches = 0;
  int checked = 0;

  // Pin level: the design wins only while it enables its driver
  assign txHighFreqClockIn = txHighFreqClockOe_n ? extTx : txHighFreqClockOut;

  acfm_top acfm_top_inst (.core_clk, .reset_n, .regAddr, .regWriteData,
    .regWrite, .regRead, .regReadData, .txHighFreqClockIn,
    .txHighFreqClockOut, .txHighFreqClockOe_n, .rxHighFreqClock,
    .txDataValid, .txDataBit, .txSerialOut, .txSectionReset, .txFailIrq,
    .rxFailIrq, .muteOut);

  acfm_clock_source acfm_clock_source_inst (.core_clk, .stopTx, .stopRx,
    .txClk(extTx), .rxClk(rxHighFreqClock));

  always #25 core_clk = ~core_clk;

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic cb(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask : cb

  task automatic cw(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: reg %h expected %h", $time, got, exp);
    end
  endtask : cw

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= v;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    cw(d, exp);
  endtask : rc

  // Sync delay of the sampled clock may shift a window by one count
  task automatic cnt(input logic [7:0] a, input int lo, input int hi);
    rd(a);
    cb(d[31:24] >= lo && d[31:24] <= hi, 1'b1);
  endtask : cnt

  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask : tick

  initial begin
    #3_000_000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rc(OFF_TX_CHECK, 32'h00ff0000);
    rc(OFF_RX_CHECK, 32'h00ff0000);
    rc(8'h24, 32'h0);
    cb(muteOut, 1'b1);
    cb(txHighFreqClockOe_n, 1'b1);
    // Startup: configure, clear, measure; 4 clocks per period, 128 a window
    wr(OFF_TX_HCLK, 32'h200);
    wr(OFF_TX_CHECK, 32'h00c86400);
    tick(400);
    wr(OFF_TX_STATUS, 32'h1);
    tick(300);
    rc(OFF_TX_STATUS, 32'h0);
    cnt(OFF_TX_CHECK, 127, 129);
    wr(OFF_TX_CHECK, 32'h00c89000);
    tick(300);
    rc(OFF_TX_STATUS, 32'h1);
    cb(txFailIrq, 1'b0);
    wr(OFF_TX_INT, 32'h1);
    tick(2);
    cb(txFailIrq, 1'b1);
    wr(OFF_TX_STATUS, 32'h0);
    rc(OFF_TX_STATUS, 32'h1);
    wr(OFF_TX_CHECK, 32'h00700000);
    tick(10);
    wr(OFF_TX_STATUS, 32'h1);
    tick(300);
    rc(OFF_TX_STATUS, 32'h1);
    wr(OFF_TX_CHECK, 32'h00c83001);
    tick(400);
    wr(OFF_TX_STATUS, 32'h1);
    rc(OFF_TX_STATUS, 32'h0);
    tick(2);
    cb(txFailIrq, 1'b0);
    tick(300);
    cnt(OFF_TX_CHECK, 63, 65);
    wr(OFF_MUTE, 32'h1);
    stopTx <= 1'b1;
    tick(600);
    rc(OFF_TX_STATUS, 32'h1);
    cb(muteOut, 1'b0);
    stopTx <= 1'b0;
    wr(OFF_MUTE, 32'h0);
    tick(2);
    cb(muteOut, 1'b1);
    wr(OFF_TX_INT, 32'h0);
    // Receive check; its autoswitch bit does not exist
    wr(OFF_MODE, 32'h2);
    wr(OFF_RX_CHECK, 32'h00c86480);
    tick(400);
    wr(OFF_RX_STATUS, 32'h1);
    tick(300);
    rc(OFF_RX_STATUS, 32'h0);
    cnt(OFF_RX_CHECK, 127, 129);
    cb(d[7], 1'b0);
    wr(OFF_RX_INT, 32'h1);
    wr(OFF_MUTE, 32'h6);
    wr(OFF_RX_CHECK, 32'h00c89000);
    tick(300);
    rc(OFF_RX_STATUS, 32'h1);
    cb(rxFailIrq, 1'b1);
    cb(muteOut, 1'b1);
    wr(OFF_RX_CHECK, 32'h00c80000);
    tick(10);
    wr(OFF_RX_STATUS, 32'h1);
    rc(OFF_RX_STATUS, 32'h0);
    stopRx <= 1'b1;
    tick(400);
    rc(OFF_RX_STATUS, 32'h1);
    // Autoswitch with divide ratio 3, one divider period of 8 clocks
    wr(OFF_MUTE, 32'h0);
    wr(OFF_TX_CHECK, 32'h00c86400);
    wr(OFF_TX_HCLK, 32'h203);
    wr(OFF_MODE, 32'h1);
    tick(400);
    wr(OFF_TX_STATUS, 32'h1);
    tick(300);
    rc(OFF_TX_STATUS, 32'h0);
    wr(OFF_TX_CHECK, 32'h00c86480);
    stopTx <= 1'b1;
    n = 0;
    while (txSectionReset !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    n = 0;
    while (txSectionReset === 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    cb(n == 8 || n == 9, 1'b1);
    tick(4);
    for (int i = 0; i < 8; i++) begin
      s[i] = txSerialOut;
      tick(8);
    end
    for (int i = 0; i < 6; i++) cb(s[i + 2], ~s[i]);
    cb(s[0], 1'b1);
    cb(s[1], 1'b1);
    rc(OFF_TX_HCLK, 32'h303);
    cb(txHighFreqClockOe_n, 1'b1);
    @(posedge core_clk);
    txDataValid <= 1'b1;
    txDataBit <= 1'b1;
    tick(24);
    cb(txSerialOut, 1'b1);
    tick(8);
    cb(txSerialOut, 1'b1);
    // Pin driven by the divider once the flag is cleared
    wr(OFF_TX_CHECK, 32'h00ff0001);
    tick(300);
    wr(OFF_TX_STATUS, 32'h1);
    tick(2);
    rc(OFF_TX_STATUS, 32'h0);
    cb(txHighFreqClockOe_n, 1'b0);
    s[0] = txHighFreqClockOut;
    tick(4);
    cb(txHighFreqClockOut, ~s[0]);
    // Back to the external clock, then the startup steps again
    stopTx <= 1'b0;
    wr(OFF_TX_HCLK, 32'h203);
    wr(OFF_TX_CHECK, 32'h00c86400);
    tick(400);
    wr(OFF_TX_STATUS, 32'h1);
    tick(300);
    rc(OFF_TX_STATUS, 32'h0);
    cnt(OFF_TX_CHECK, 127, 129);
    conclude();
  end
endmodule : acfm_top_bench
